//--- verilog/sra_regs.svh
// timing constants for the sample-ready / sync-reset / serial link block
`ifndef SRA_REGS_SVH
`define SRA_REGS_SVH
`define SRA_CLK_MHZ        40
`define SRA_SYNC_MIN_CYC   12'd1
`define SRA_SYNC_MAX_CYC   12'd2047
`define SRA_RESET_CYC      12'd2048
`define SRA_READY_HIGH_CYC 4
`define SRA_READY_LOW_CYC  4
`define SRA_POR_TIME_US    250
`define SRA_POR_CYC        (`SRA_POR_TIME_US * `SRA_CLK_MHZ)
`define SRA_LOAD_TIME_US   5
`define SRA_LOAD_CYC       (`SRA_LOAD_TIME_US * `SRA_CLK_MHZ)
`define SRA_TIMEOUT_CYC    32768
`define SRA_CONV_CYC       1024
`define SRA_FRAME_BITS     24
`endif

//--- verilog/sra_pkg.sv
// types for the sample-ready / sync-reset / serial link block
package sra_pkg;
    typedef enum logic [2:0] {
        ST_LOAD = 3'b001,
        ST_POR  = 3'b010,
        ST_RUN  = 3'b100
    } sra_state_t;

    typedef struct packed {
        logic        valid;
        logic [23:0] word;
    } sra_rx_t;
endpackage

//--- verilog/sra_top.sv
// sync/reset pulse decode, sample-ready timing and serial link gating
`timescale 1ns/1ps
`default_nettype none
`include "sra_regs.svh"
module sra_top
    import sra_pkg::*;
#(
    parameter int POR_CYC     = `SRA_POR_CYC,
    parameter int TIMEOUT_CYC = `SRA_TIMEOUT_CYC,
    parameter int CONV_CYC    = `SRA_CONV_CYC
)(
    // master clock and reset
    input  wire logic    CLOCK,
    input  wire logic    RST_B,
    // sync/reset pin
    input  wire logic    SYNC_RESET_N,
    // serial link
    input  wire logic    SCLK,
    input  wire logic    CS_N,
    input  wire logic    DIN,
    output logic         DOUT,
    output logic         DOUT_OE,
    // user side
    input  wire logic [23:0] TX_WORD,
    output sra_rx_t      RX,
    output logic         SAMPLE_READY_N,
    output logic         REGS_VALID,
    output logic         SYNC_PULSE,
    output logic         FRAME_ABORT
);
    localparam int NB = `SRA_FRAME_BITS;

    // synchronisers for the sync and select pins and the link-side frame and done flags
    logic       sy_s1, sy_s2;
    logic       cs_s1, cs_s2;
    logic       fo_s1, fo_s2;
    logic       dt_s1, dt_s2, dt_s3;
    // sync/reset measurement
    logic [11:0] low_cnt;
    logic        soft_rst;
    // power-up sequencing and ready pulses
    sra_state_t  state;
    logic [15:0] up_cnt;
    logic [15:0] conv_cnt;
    logic [2:0]  rdy_low;
    // serial link
    logic [15:0] to_cnt;
    logic [23:0] tx_hold;
    logic [23:0] tx_shift;
    logic [23:0] rx_shift;
    logic [23:0] rx_word_l;
    logic [4:0]  tx_cnt;
    logic [4:0]  rx_cnt;
    logic        frame_open;
    logic        done_tgl;

    wire logic sync_req  = sy_s2 && low_cnt >= `SRA_SYNC_MIN_CYC
                           && low_cnt <= `SRA_SYNC_MAX_CYC;
    wire logic long_low  = !sy_s2 && low_cnt == `SRA_RESET_CYC - 12'd1;
    wire logic load_done = up_cnt == 16'(`SRA_LOAD_CYC - 1);
    wire logic por_done  = up_cnt == 16'(POR_CYC - 1);
    wire logic conv_end  = conv_cnt == 16'(CONV_CYC - 1);
    wire logic low_start = conv_cnt == 16'(CONV_CYC - `SRA_READY_LOW_CYC);
    wire logic low_end   = !SAMPLE_READY_N && rdy_low == 3'(`SRA_READY_LOW_CYC - 1);
    wire logic timeout   = fo_s2 && to_cnt == 16'(TIMEOUT_CYC - 1);
    wire logic word_done = dt_s2 ^ dt_s3;
    // link logic restarts on chip-select high, a timeout or a device reset
    wire logic link_rst_n = RST_B && !FRAME_ABORT && !soft_rst && !CS_N;
    wire logic tx_first  = tx_cnt == 5'd0;
    wire logic rx_last   = rx_cnt == 5'(NB - 1);

    // pin crossings, read at the second stage, the done toggle also at the third
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            {sy_s1, sy_s2} <= 2'h3;
            {cs_s1, cs_s2} <= 2'h3;
            {fo_s1, fo_s2} <= 2'h0;
            {dt_s1, dt_s2, dt_s3} <= 3'h0;
        end
        else
        begin
            {sy_s1, sy_s2} <= {SYNC_RESET_N, sy_s1};
            {cs_s1, cs_s2} <= {CS_N, cs_s1};
            {fo_s1, fo_s2} <= {frame_open, fo_s1};
            {dt_s1, dt_s2, dt_s3} <= {done_tgl, dt_s1, dt_s2};
        end
    end

    // low time of the sync/reset pin, saturating at the reset length
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            low_cnt    <= 12'h000;
            soft_rst   <= 1'b0;
            SYNC_PULSE <= 1'b0;
        end
        else
        begin
            if (sy_s2)
                low_cnt <= 12'h000;
            else if (low_cnt != `SRA_RESET_CYC)
                low_cnt <= low_cnt + 12'h001;
            soft_rst   <= long_low;
            SYNC_PULSE <= sync_req;
        end
    end

    // power-up: defaults load first, ready held low until the power-up time
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            state          <= ST_LOAD;
            up_cnt         <= 16'h0000;
            conv_cnt       <= 16'h0000;
            rdy_low        <= 3'h0;
            REGS_VALID     <= 1'b0;
            SAMPLE_READY_N <= 1'b0;
        end
        else if (soft_rst)
        begin
            state          <= ST_LOAD;
            up_cnt         <= 16'h0000;
            conv_cnt       <= 16'h0000;
            rdy_low        <= 3'h0;
            REGS_VALID     <= 1'b0;
            SAMPLE_READY_N <= 1'b0;
        end
        else
        begin
            case (state)
                ST_LOAD:
                begin
                    up_cnt <= up_cnt + 16'h0001;
                    if (load_done)
                    begin
                        REGS_VALID <= 1'b1;
                        state      <= ST_POR;
                    end
                end
                ST_POR:
                begin
                    up_cnt <= up_cnt + 16'h0001;
                    if (por_done)
                    begin
                        SAMPLE_READY_N <= 1'b1;
                        state          <= ST_RUN;
                    end
                end
                ST_RUN:
                begin
                    // sync restarts the period; a low pulse already begun still runs full length
                    if (SYNC_PULSE || conv_end)
                        conv_cnt <= 16'h0000;
                    else
                        conv_cnt <= conv_cnt + 16'h0001;
                    rdy_low <= SAMPLE_READY_N ? 3'h0 : rdy_low + 3'h1;
                    if (low_start && SAMPLE_READY_N)
                        SAMPLE_READY_N <= 1'b0;
                    else if (low_end)
                        SAMPLE_READY_N <= 1'b1;
                end
                default:
                    state <= ST_LOAD;
            endcase
        end
    end

    // frame timeout, word pickup and output enable
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            to_cnt      <= 16'h0000;
            FRAME_ABORT <= 1'b0;
            DOUT_OE     <= 1'b0;
            tx_hold     <= 24'h000000;
            RX          <= '0;
        end
        else
        begin
            to_cnt      <= (fo_s2 && !timeout) ? to_cnt + 16'h0001 : 16'h0000;
            FRAME_ABORT <= timeout;
            DOUT_OE     <= !cs_s2;
            // frozen while selected, host only moves select with the clock low
            if (cs_s2)
                tx_hold <= TX_WORD;
            RX.valid <= word_done;
            if (word_done)
                RX.word <= rx_word_l;
        end
    end

    // link side: new bit after the rising edge
    always_ff @(posedge SCLK or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            DOUT     <= 1'b0;
            tx_shift <= 24'h000000;
            tx_cnt   <= 5'd0;
        end
        else
        begin
            DOUT     <= tx_first ? tx_hold[NB-1] : tx_shift[NB-1];
            tx_shift <= tx_first ? {tx_hold[NB-2:0], 1'b0}
                                 : {tx_shift[NB-2:0], 1'b0};
            tx_cnt   <= (tx_cnt == 5'(NB - 1)) ? 5'd0 : tx_cnt + 5'd1;
        end
    end

    // link side: capture on the falling edge
    always_ff @(negedge SCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            rx_word_l <= 24'h000000;
            done_tgl  <= 1'b0;
        end
        else if (link_rst_n && rx_last)
        begin
            rx_word_l <= {rx_shift[NB-2:0], DIN};
            done_tgl  <= !done_tgl;
        end
    end

    always_ff @(negedge SCLK or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            rx_shift   <= 24'h000000;
            rx_cnt     <= 5'd0;
            frame_open <= 1'b0;
        end
        else
        begin
            rx_shift   <= {rx_shift[NB-2:0], DIN};
            rx_cnt     <= rx_last ? 5'd0 : rx_cnt + 5'd1;
            frame_open <= !rx_last;
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_B);

    ready_low_len_a: assert property ($fell(SAMPLE_READY_N) && state == ST_RUN
        |-> !SAMPLE_READY_N [*4] ##1 (SAMPLE_READY_N || state != ST_RUN))
        else $error("ready low pulse not four cycles");
    ready_high_len_a: assert property ($rose(SAMPLE_READY_N) && !soft_rst
        |-> (SAMPLE_READY_N || state != ST_RUN) [*4])
        else $error("ready high shorter than four cycles");
    sync_short_a: assert property ($rose(sy_s2) && low_cnt >= 12'd1
        && low_cnt <= 12'd2047 |=> SYNC_PULSE && !soft_rst)
        else $error("short low pulse not taken as sync");
    reset_long_a: assert property (!sy_s2 && low_cnt == 12'd2047
        |=> soft_rst ##1 !REGS_VALID)
        else $error("long low pulse did not reset");
    sync_count_a: assert property (!sy_s2 && low_cnt < 12'd2048
        |=> low_cnt == $past(low_cnt) + 12'd1 || soft_rst)
        else $error("low time not counted per clock");
    load_time_a: assert property ($rose(REGS_VALID) |-> up_cnt == 16'(`SRA_LOAD_CYC))
        else $error("defaults valid at wrong time");
    first_ready_a: assert property ($rose(SAMPLE_READY_N) && $past(state) == ST_POR
        |-> up_cnt == 16'(POR_CYC))
        else $error("first ready edge at wrong time");
    timeout_abort_a: assert property (fo_s2 && to_cnt == 16'(TIMEOUT_CYC - 1)
        |=> FRAME_ABORT ##3 !fo_s2)
        else $error("stale frame not abandoned");
    dout_enable_a: assert property (!cs_s2 |=> DOUT_OE)
        else $error("output not driven while selected");
    dout_release_a: assert property (cs_s2 |=> !DOUT_OE && !DOUT)
        else $error("output not released when deselected");
endmodule
`default_nettype wire

//--- verif/sra_host.sv
// serial master model standing in for the host side of the link
`timescale 1ns/1ps
`default_nettype none
module sra_host (
    // serial link
    output logic      SCLK,
    output logic      CS_N,
    output logic      DIN,
    input  wire logic DOUT
);
    initial
    begin
        SCLK = 1'b0;
        CS_N = 1'b1;
        DIN  = 1'b0;
    end

    // clock only runs inside a frame; data changes on rise, device takes it on fall
    task automatic xfer(input logic [23:0] d, input int nbits, input bit hold,
                        output logic [23:0] got);
        got  = 24'h000000;
        CS_N = 1'b0;
        #100;
        for (int i = 0; i < nbits; i++)
        begin
            SCLK = 1'b1;
            DIN  = d[23 - i];
            #6;
            SCLK = 1'b0;
            got  = {got[22:0], DOUT};
            #6;
        end
        if (!hold)
            release_cs();
    endtask

    // deselect with the clock low; released data line shows no stale value
    task automatic release_cs();
        #10;
        CS_N = 1'b1;
        DIN  = ~DIN;
    endtask
endmodule
`default_nettype wire

//--- verif/sra_top_test.sv
// self-checking bench for sync/reset decode, sample-ready timing and the link
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin mismatches++; \
    $display("BAD %0t %s", $time, m); end end
module sra_top_test;
    import sra_pkg::*;
    typedef struct packed { logic [23:0] tx; logic [23:0] rx; } sra_row_t;
    localparam int POR = 300;
    localparam int TMO = 64;
    localparam int CONV = 32;
    logic        CLOCK, RST_B, SYNC_RESET_N, SCLK, CS_N, DIN, DOUT, DOUT_OE;
    logic        SAMPLE_READY_N, REGS_VALID, SYNC_PULSE, FRAME_ABORT;
    logic [23:0] TX_WORD, got;
    sra_rx_t     RX;
    wire  [5:0]  mon = {DOUT_OE, FRAME_ABORT, SYNC_PULSE, RX.valid, SAMPLE_READY_N, REGS_VALID};
    int          mismatches = 0, compares = 0, n, t0, cyc = 0;
    sra_row_t    rows [3] = '{{24'h000000, 24'hFFFFFF}, {24'hA5A5A5, 24'h5A5A5A},
                              {24'h800001, 24'h123456}};

    sra_top #(.POR_CYC(POR), .TIMEOUT_CYC(TMO), .CONV_CYC(CONV)) sra_top_i (
        .CLOCK(CLOCK), .RST_B(RST_B), .SYNC_RESET_N(SYNC_RESET_N), .SCLK(SCLK),
        .CS_N(CS_N), .DIN(DIN), .DOUT(DOUT), .DOUT_OE(DOUT_OE), .TX_WORD(TX_WORD),
        .RX(RX), .SAMPLE_READY_N(SAMPLE_READY_N), .REGS_VALID(REGS_VALID),
        .SYNC_PULSE(SYNC_PULSE), .FRAME_ABORT(FRAME_ABORT));
    sra_host sra_host_i (.SCLK(SCLK), .CS_N(CS_N), .DIN(DIN), .DOUT(DOUT));

    initial
    begin
        CLOCK = 1'b0;
        forever #12.5 CLOCK = ~CLOCK;
    end
    always @(posedge CLOCK) cyc <= cyc + 1;

    task automatic end_sim();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // bounded wait on one monitored output, counting falling clock edges
    task automatic wait_on(input int sel, input logic lvl, input int lim, output int k);
        k = 0;
        while (k < lim && mon[sel] !== lvl)
        begin
            @(negedge CLOCK);
            k++;
        end
        if (k >= lim)
        begin
            mismatches++;
            $display("BAD %0t wait ran out", $time);
            end_sim();
        end
    endtask

    task automatic do_row(input sra_row_t r);
        @(negedge CLOCK);
        TX_WORD = r.tx;
        repeat (4) @(negedge CLOCK);
        sra_host_i.xfer(r.rx, 24, 1'b0, got);
        wait_on(2, 1'b1, 20, n);
        `CHK(RX.word, r.rx, "word received")
        `CHK(got, r.tx, "word sent")
        wait_on(5, 1'b0, 10, n);
    endtask

    // pulses of the sync pin measured in master clock periods
    task automatic sync_low(input int len);
        @(negedge CLOCK);
        SYNC_RESET_N = 1'b0;
        repeat (len) @(negedge CLOCK);
        SYNC_RESET_N = 1'b1;
    endtask

    initial
    begin
        RST_B = 1'b0;
        SYNC_RESET_N = 1'b1;
        TX_WORD = 24'h000000;
        repeat (3) @(negedge CLOCK);
        `CHK(mon[5:0], 6'h00, "reset state")
        RST_B = 1'b1;
        t0 = cyc;
        wait_on(0, 1'b1, 400, n);
        `CHK(cyc - t0 >= 198 && cyc - t0 <= 202, 1'b1, "load time")
        wait_on(1, 1'b1, POR, n);
        `CHK(cyc - t0 >= POR - 2 && cyc - t0 <= POR + 2, 1'b1, "power-up time")
        wait_on(1, 1'b0, CONV + 4, n);
        wait_on(1, 1'b1, 10, n);
        `CHK(n, 4, "ready low length")
        wait_on(1, 1'b0, CONV + 4, n);
        `CHK(n, CONV - 4, "ready high length")
        foreach (rows[i])
            do_row(rows[i]);
        // partial frame left hanging until the link gives up
        sra_host_i.xfer(24'hF0F0F0, 10, 1'b1, got);
        `CHK(DOUT_OE, 1'b1, "output driven")
        wait_on(4, 1'b1, TMO + 20, n);
        `CHK(n >= TMO - 12, 1'b1, "timeout too early")
        sra_host_i.release_cs();
        do_row(rows[1]);
        sync_low(1);
        wait_on(3, 1'b1, 8, n);
        sync_low(2047);
        wait_on(3, 1'b1, 8, n);
        sync_low(2052);
        `CHK(REGS_VALID, 1'b0, "soft reset")
        repeat (8)
        begin
            @(negedge CLOCK);
            `CHK(SYNC_PULSE, 1'b0, "no sync on reset")
        end
        wait_on(0, 1'b1, 400, n);
        end_sim();
    end
endmodule
`default_nettype wire
